/* logic/bmrw_pkg.sv */
`default_nettype none
package bmrw_pkg;

  // Data path width of the peripheral bus and of the port
  localparam int unsigned BMRW_BYTE_W = 8;
  localparam int unsigned BMRW_BIT_IDX_W = 3;

  // Operations issued by the CPU core
  typedef enum logic [2:0] {
    BMRW_OP_BYTE_READ = 3'b000,
    BMRW_OP_BYTE_WRITE = 3'b001,
    BMRW_OP_BIT_SET = 3'b010,
    BMRW_OP_BIT_CLEAR = 3'b011,
    BMRW_OP_BIT_INVERT = 3'b100,
    BMRW_OP_BIT_STORE = 3'b101,
    BMRW_OP_BIT_INV_STORE = 3'b110
  } bmrw_op_e;

  // Target selects on the peripheral byte bus
  typedef enum logic [1:0] {
    BMRW_SEL_PORT_DATA = 2'b00,
    BMRW_SEL_PORT_DIR = 2'b01,
    BMRW_SEL_TIMER = 2'b10,
    BMRW_SEL_NONE = 2'b11
  } bmrw_sel_e;

  // Sequencer states
  typedef enum logic [1:0] {
    BMRW_ST_IDLE = 2'b00,
    BMRW_ST_READ = 2'b01,
    BMRW_ST_MODIFY = 2'b10,
    BMRW_ST_WRITE = 2'b11
  } bmrw_state_e;

  // Reset values and the unmapped read value
  localparam logic [7:0] BMRW_LATCH_RST = 8'h00;
  localparam logic [7:0] BMRW_DIR_RST = 8'h00;
  localparam logic [7:0] BMRW_RELOAD_RST = 8'h00;
  localparam logic [7:0] BMRW_COUNT_RST = 8'h00;
  localparam logic [7:0] BMRW_UNMAPPED_READ = 8'h00;

  // Apply one bit operation to a byte; byte moves pass through untouched
  function automatic logic [7:0] bmrw_modify(input logic [7:0] byte_in, input bmrw_op_e op,
                                             input logic [2:0] idx, input logic carry);
    logic [7:0] res;
    res = byte_in;
    unique case (op)
      BMRW_OP_BIT_SET: res[idx] = 1'b1;
      BMRW_OP_BIT_CLEAR: res[idx] = 1'b0;
      BMRW_OP_BIT_INVERT: res[idx] = ~byte_in[idx];
      BMRW_OP_BIT_STORE: res[idx] = carry;
      BMRW_OP_BIT_INV_STORE: res[idx] = ~carry;
      default: res = byte_in;
    endcase
    return res;
  endfunction

endpackage
`default_nettype wire

/* logic/bmrw_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bmrw_timer
  import bmrw_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic i_reload_we,
  input wire logic [WIDTH-1:0] i_reload_data,
  output logic [WIDTH-1:0] o_count,
  output logic [WIDTH-1:0] o_reload
);

  generate
    if (WIDTH != BMRW_BYTE_W) begin : g_bad_width
      $error("bmrw_timer supports only byte width");
    end
  endgenerate

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] reload_q;

  // Reload register; only the shared-address write reaches it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reload_q <= BMRW_RELOAD_RST;
    end else if (i_reload_we) begin
      reload_q <= i_reload_data;
    end
  end

  // Up counter, reloads after reaching all ones; a bus write never touches it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_q <= BMRW_COUNT_RST;
    end else if (i_run) begin
      if (&count_q) begin
        count_q <= reload_q;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign o_count = count_q;
  assign o_reload = reload_q;

endmodule
`default_nettype wire

/* logic/bmrw_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bmrw_top
  import bmrw_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_op_valid,
  input wire logic [2:0] i_op_code,
  input wire logic [1:0] i_op_sel,
  input wire logic [2:0] i_op_bit,
  input wire logic i_op_carry,
  input wire logic [7:0] i_op_wdata,
  input wire logic [PORT_W-1:0] i_port_pin,
  input wire logic i_timer_run,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [PORT_W-1:0] o_port_out,
  output logic [PORT_W-1:0] o_port_oe,
  output logic [7:0] o_timer_count,
  output logic [7:0] o_timer_reload
);

  generate
    if (PORT_W != BMRW_BYTE_W) begin : g_bad_port
      $error("bmrw_top supports only a byte-wide port");
    end
  endgenerate

  bmrw_state_e state_q;
  bmrw_state_e state_d;
  bmrw_op_e op_q;
  bmrw_sel_e sel_q;
  logic [2:0] bit_q;
  logic carry_q;
  logic [7:0] work_q;
  logic busy_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] dir_q;
  logic [7:0] read_byte;
  logic write_en;
  logic [7:0] count_w;
  logic [7:0] reload_w;
  logic reload_we;

  // Byte seen on a read of the selected target
  always_comb begin
    read_byte = BMRW_UNMAPPED_READ;
    unique case (sel_q)
      BMRW_SEL_PORT_DATA: read_byte = (dir_q & latch_q) | (~dir_q & i_port_pin);
      BMRW_SEL_PORT_DIR: read_byte = dir_q;
      BMRW_SEL_TIMER: read_byte = count_w;
      BMRW_SEL_NONE: read_byte = BMRW_UNMAPPED_READ;
    endcase
  end

  // Write strobe toward the targets in the last phase
  assign write_en = (state_q == BMRW_ST_WRITE);
  // Shared address write lands in reload only
  assign reload_we = write_en && (sel_q == BMRW_SEL_TIMER);

  // Next state of the read-modify-write sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BMRW_ST_IDLE: begin
        if (i_op_valid) begin
          if (bmrw_op_e'(i_op_code) == BMRW_OP_BYTE_WRITE) begin
            state_d = BMRW_ST_WRITE;
          end else begin
            state_d = BMRW_ST_READ;
          end
        end
      end
      // Read phase then modify, except a plain byte read
      BMRW_ST_READ: begin
        if (op_q == BMRW_OP_BYTE_READ) begin
          state_d = BMRW_ST_IDLE;
        end else begin
          state_d = BMRW_ST_MODIFY;
        end
      end
      BMRW_ST_MODIFY: state_d = BMRW_ST_WRITE;
      BMRW_ST_WRITE: state_d = BMRW_ST_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= BMRW_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture when idle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      op_q <= BMRW_OP_BYTE_READ;
      sel_q <= BMRW_SEL_NONE;
      bit_q <= 3'h0;
      carry_q <= 1'b0;
    end else if (state_q == BMRW_ST_IDLE && i_op_valid) begin
      op_q <= bmrw_op_e'(i_op_code);
      sel_q <= bmrw_sel_e'(i_op_sel);
      bit_q <= i_op_bit;
      carry_q <= i_op_carry;
    end
  end

  // Working copy of the byte
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      work_q <= 8'h00;
    end else begin
      unique case (state_q)
        BMRW_ST_IDLE: begin
          if (i_op_valid) begin
            work_q <= i_op_wdata;
          end
        end
        // Whole byte read into the copy
        BMRW_ST_READ: work_q <= read_byte;
        BMRW_ST_MODIFY: work_q <= bmrw_modify(work_q, op_q, bit_q, carry_q);
        BMRW_ST_WRITE: work_q <= work_q;
      endcase
    end
  end

  // Port output latch
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      latch_q <= BMRW_LATCH_RST;
    end else if (write_en && sel_q == BMRW_SEL_PORT_DATA) begin
      // Every latch bit written, inputs included
      latch_q <= work_q;
    end
  end

  // Port direction register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dir_q <= BMRW_DIR_RST;
    end else if (write_en && sel_q == BMRW_SEL_PORT_DIR) begin
      dir_q <= work_q;
    end
  end

  // Pin drive outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_port_out <= BMRW_LATCH_RST;
      o_port_oe <= BMRW_DIR_RST;
    end else begin
      o_port_out <= (write_en && sel_q == BMRW_SEL_PORT_DATA) ? work_q : latch_q;
      o_port_oe <= (write_en && sel_q == BMRW_SEL_PORT_DIR) ? work_q : dir_q;
    end
  end

  // Handshake toward the CPU core
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      busy_q <= (state_d != BMRW_ST_IDLE);
      done_q <= 1'b0;
      if (state_q == BMRW_ST_READ && op_q == BMRW_OP_BYTE_READ) begin
        done_q <= 1'b1;
        rdata_q <= read_byte;
      end else if (write_en) begin
        done_q <= 1'b1;
        rdata_q <= work_q;
      end
    end
  end

  // Reloadable timer sharing one address
  // Modified counter byte on a bit op, or the byte of a byte write, written into reload
  bmrw_timer #(
    .WIDTH(BMRW_BYTE_W)
  ) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_run(i_timer_run),
    .i_reload_we(reload_we),
    .i_reload_data(work_q),
    .o_count(count_w),
    .o_reload(reload_w)
  );

  // Timer view registered for the outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_timer_count <= BMRW_COUNT_RST;
      o_timer_reload <= BMRW_RELOAD_RST;
    end else begin
      o_timer_count <= count_w;
      o_timer_reload <= reload_w;
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

/* test/bmrw_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module bmrw_checker
  import bmrw_pkg::*;
#(parameter int unsigned PORT_W = 8) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_op_valid,
  input wire logic [2:0] i_op_code,
  input wire logic [1:0] i_op_sel,
  input wire logic [PORT_W-1:0] i_port_pin,
  input wire logic i_timer_run,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_rdata,
  input wire logic [PORT_W-1:0] o_port_out,
  input wire logic [PORT_W-1:0] o_port_oe,
  input wire logic [7:0] o_timer_count,
  input wire logic [7:0] o_timer_reload
);
  logic [2:0] code_q;
  logic [1:0] sel_q;
  logic rd;
  logic wr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Remember the request in service
  always_ff @(posedge i_clk) begin
    if (i_op_valid && !o_busy) begin
      code_q <= i_op_code;
      sel_q <= i_op_sel;
    end
  end
  // Completion of a read or of a write-back
  assign rd = o_done && code_q == 3'h0;
  assign wr = o_done && code_q != 3'h0;
  // Accept edge, three busy samples for read, modify and write, then done
  rmw_len_a: assert property (i_op_valid && !o_busy && i_op_code inside {[3'h2:3'h6]}
    |=> o_busy [*3] ##1 o_done && !o_busy) else $error("bit op timing wrong");
  busy_done_a: assert property ($fell(o_busy) |-> o_done) else $error("busy fell early");
  latch_wr_a: assert property (wr && sel_q == 2'h0 |-> o_port_out == o_rdata)
    else $error("latch not written");
  dir_wr_a: assert property (wr && sel_q == 2'h1 |-> o_port_oe == o_rdata)
    else $error("direction not written");
  reload_wr_a: assert property (
    wr && sel_q == 2'h2 |=> o_timer_reload == $past(o_rdata)) else $error("reload wrong");
  // Pins as they stood at the edge that took the read byte
  pin_rd_a: assert property (
    rd && sel_q == 2'h0 |-> ((o_rdata ^ $past(i_port_pin)) & ~o_port_oe) == 8'h00)
    else $error("input bit not pin");
  latch_rd_a: assert property (
    rd && sel_q == 2'h0 |-> ((o_rdata ^ o_port_out) & o_port_oe) == 8'h00)
    else $error("output bit not latch");
  count_rd_a: assert property (
    rd && sel_q == 2'h2 && !i_timer_run |-> o_rdata == o_timer_count)
    else $error("timer read not counter");
  cover property (wr && sel_q == 2'h0 && code_q == 3'h2);
  cover property (rd && sel_q == 2'h2);
  cover property (wr && sel_q == 2'h2 && code_q == 3'h2);
endmodule
`default_nettype wire

/* test/bmrw_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bmrw_cpu_model (
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic [7:0] i_rdata,
  output var logic o_valid,
  output var logic [2:0] o_code,
  output var logic [1:0] o_sel,
  output var logic [2:0] o_bit,
  output var logic o_carry,
  output var logic [7:0] o_wdata
);
  logic [7:0] shadow_q;
  // Idle request lines
  initial begin
    o_valid = 1'b0;
    o_code = 3'h0;
    o_sel = 2'h3;
    o_bit = 3'h0;
    o_carry = 1'b0;
    o_wdata = 8'h00;
  end
  // One request, held for its accept edge, then wait for done
  task automatic op(input logic [2:0] c, input logic [1:0] s, input logic [2:0] b,
                    input logic cy, input logic [7:0] w, output logic [7:0] r, output bit ok);
    int n;
    @(negedge i_clk);
    o_valid = 1'b1;
    o_code = c;
    o_sel = s;
    o_bit = b;
    o_carry = cy;
    o_wdata = w;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_bit = ~b;
    o_carry = ~cy;
    o_wdata = ~w;
    n = 0;
    while (i_done !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    ok = i_done === 1'b1;
    r = i_rdata;
  endtask
  task automatic shadow_bit(input logic [2:0] b, output logic [7:0] r, output bit ok);
    shadow_q[b] = 1'b1;
    op(3'h1, 2'h0, 3'h0, 1'b0, shadow_q, r, ok);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bmrw_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_timer_run = 1'b0;
  logic [7:0] pin = 8'h40;
  logic i_op_valid, i_op_carry, o_busy, o_done;
  logic [2:0] i_op_code, i_op_bit;
  logic [1:0] i_op_sel;
  logic [7:0] i_op_wdata, r, o_rdata, o_port_out, o_port_oe, o_timer_count, o_timer_reload;
  int mismatches = 0;
  int total_checks = 0;
  bit ok;
  always #25 i_clk = ~i_clk;
  // Driven pins follow the latch, the others see low on bit 7, high on bit 6
  always @(negedge i_clk) pin <= (o_port_out & o_port_oe) | (8'h40 & ~o_port_oe);
  bmrw_top u_bmrw_top (.i_clk, .i_reset, .i_op_valid, .i_op_code, .i_op_sel, .i_op_bit,
    .i_op_carry, .i_op_wdata, .i_port_pin(pin), .i_timer_run, .o_busy, .o_done, .o_rdata,
    .o_port_out, .o_port_oe, .o_timer_count, .o_timer_reload);
  bmrw_cpu_model u_bmrw_cpu_model (.i_clk, .i_done(o_done), .i_rdata(o_rdata),
    .o_valid(i_op_valid), .o_code(i_op_code), .o_sel(i_op_sel), .o_bit(i_op_bit),
    .o_carry(i_op_carry), .o_wdata(i_op_wdata));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // A request that never completes counts as a mismatch and ends the run
  task automatic chk_ok();
    if (!ok) begin
      mismatches++;
      $display("BAD %0t no done", $time);
      test_done();
    end
  endtask
  task automatic go(input logic [2:0] c, input logic [1:0] s, input logic [2:0] b,
                    input logic cy, input logic [7:0] w);
    u_bmrw_cpu_model.op(c, s, b, cy, w, r, ok);
    chk_ok();
  endtask
  // Bit set on the port rewrites input latch bits from the pins
  task automatic t_port();
    go(3'h1, 2'h1, 3'h0, 1'b0, 8'h3F);
    go(3'h1, 2'h0, 3'h0, 1'b0, 8'h80);
    chk(o_port_oe, 8'h3F);
    chk(o_port_out, 8'h80);
    go(3'h0, 2'h0, 3'h0, 1'b0, 8'h00);
    chk(r, 8'h40);
    go(3'h2, 2'h0, 3'h0, 1'b0, 8'h00);
    chk(r, 8'h41);
    chk(o_port_out, 8'h41);
    @(negedge i_clk);
    chk(pin, 8'h41);
    u_bmrw_cpu_model.shadow_q = 8'h80;
    u_bmrw_cpu_model.shadow_bit(3'h0, r, ok);
    chk_ok();
    chk(o_port_out, 8'h81);
    $display("port test done");
  endtask
  // Shared timer address: counter read, reload written
  task automatic t_timer();
    go(3'h1, 2'h2, 3'h0, 1'b0, 8'h5A);
    go(3'h0, 2'h2, 3'h0, 1'b0, 8'h00);
    chk(r, 8'h00);
    chk(o_timer_reload, 8'h5A);
    i_timer_run = 1'b1;
    repeat (20) @(negedge i_clk);
    i_timer_run = 1'b0;
    go(3'h0, 2'h2, 3'h0, 1'b0, 8'h00);
    chk(r, 8'h14);
    go(3'h2, 2'h2, 3'h7, 1'b0, 8'h00);
    chk(r, 8'h94);
    @(negedge i_clk);
    chk(o_timer_reload, 8'h94);
    chk(o_timer_count, 8'h14);
    $display("timer test done");
  endtask
  // Every bit operation on the direction register
  task automatic t_ops();
    logic [2:0] c[5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [2:0] b[5] = '{3'h7, 3'h0, 3'h6, 3'h7, 3'h2};
    logic [7:0] e[5] = '{8'hBF, 8'hBE, 8'hFE, 8'h7E, 8'h7A};
    go(3'h1, 2'h1, 3'h0, 1'b0, 8'h3F);
    for (int k = 0; k < 5; k++) begin
      go(c[k], 2'h1, b[k], k == 4, 8'h00);
      chk(o_port_oe, e[k]);
    end
    // Unmapped target: write dropped, read gives zero
    go(3'h1, 2'h3, 3'h0, 1'b0, 8'hA5);
    chk(o_port_oe, 8'h7A);
    go(3'h0, 2'h3, 3'h0, 1'b0, 8'h00);
    chk(r, 8'h00);
    $display("ops test done");
  endtask
  initial begin
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    chk(o_port_oe, 8'h00);
    t_port();
    t_timer();
    t_ops();
    test_done();
  end
endmodule
bind bmrw_top bmrw_checker #(.PORT_W(PORT_W)) u_bmrw_checker (.i_clk, .i_reset, .i_op_valid,
  .i_op_code, .i_op_sel, .i_port_pin, .i_timer_run, .o_busy, .o_done, .o_rdata, .o_port_out,
  .o_port_oe, .o_timer_count, .o_timer_reload);
`default_nettype wire
